// *** rtl/spt_map.svh ***
/*
  Register indices, field positions, reset values and divider counts
  of the six-channel PWM timer. Assumes inclusion by bare name.
*/
`ifndef SPT_MAP_SVH
`define SPT_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define SPT_IDX_FLAG     20'hF06DF
`define SPT_IDX_OUTC0    20'hF06E2
`define SPT_IDX_OUTC1    20'hF06E4
`define SPT_IDX_CTRL     20'hF06E5
`define SPT_IDX_MON      20'hF06E6
`define SPT_IDX_TRIG     20'hF06E7
`define SPT_IDX_PERIOD   20'hF06E8
`define SPT_IDX_DUTY0    20'hF06E9

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPT_CTRL_CE      7
`define SPT_CTRL_CKS     4
`define SPT_CTRL_MD      0
`define SPT_TRIG_REQ     0
`define SPT_OUTC0_LVL    8

// ----------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------
`define SPT_NCH          6
`define SPT_CNT_IDLE     16'hFFFF
`define SPT_CMP_RST      16'h0000
`define SPT_CK0_DIV      8'h02
`define SPT_CK1_DIV      8'h08

`endif

// *** rtl/spt_pkg.sv ***
/*
  Types shared by the PWM timer modules.
  Assumes nothing of its surroundings.
*/
package spt_pkg;
  // Counter run state
  typedef enum logic {SPT_STOPPED, SPT_RUNNING} spt_state_type;
  // Per-output control bits
  typedef struct packed {
    logic en;   // Output enable
    logic lvl;  // Active level, 1 = active low
    logic def;  // Default level
  } spt_out_cfg_type;
endpackage : spt_pkg

// *** rtl/spt_tick.sv ***
/*
  Count clock generator: one-cycle tick at one of two divided rates.
  Assumes the peripheral clock and reset of the timer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spt_map.svh"

module spt_tick (
  input  wire logic ref_clk_i,  // Peripheral clock
  input  wire logic rst_b_i,    // Async reset, active low
  input  wire logic sel_i,      // Count clock select
  output logic      tick_o      // Count clock pulse
);
  logic [7:0] div_cnt;          // Divider count
  wire  [7:0] div_lim = sel_i ? (`SPT_CK1_DIV - 8'h01) : (`SPT_CK0_DIV - 8'h01);

  // ----------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt <= 8'h00;
      tick_o  <= 1'b0;
    end else if (div_cnt >= div_lim) begin
      div_cnt <= 8'h00;
      tick_o  <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      tick_o  <= 1'b0;
    end
  end
endmodule : spt_tick
`default_nettype wire

// *** rtl/spt_chan.sv ***
/*
  One PWM output stage: raw waveform, enable delay and level mapping.
  Assumes load, step and count values from the timer core.
*/
`timescale 1ns/1ps
`default_nettype none

module spt_chan (
  input  wire logic                    ref_clk_i,  // Peripheral clock
  input  wire logic                    rst_b_i,    // Async reset, active low
  input  wire logic                    run_i,      // Timer running next cycle
  input  wire logic                    load_i,     // Counter clear or start
  input  wire logic                    step_i,     // Counter increments
  input  wire logic [15:0]             cnt_next_i, // Incremented count
  input  wire logic [15:0]             duty_i,     // Duty in effect
  input  wire spt_pkg::spt_out_cfg_type cfg_i,     // Output control bits
  output logic                         pin_o       // Output level
);
  logic raw;    // Active-high waveform
  logic en_q;   // Enable seen one cycle late

  // Set at clear unless duty is zero, reset on duty match
  wire next_raw = !run_i ? 1'b0 :
                  load_i ? (duty_i != 16'h0000) :
                  (step_i && cnt_next_i == duty_i) ? 1'b0 : raw;
  // Default while stopped or disabled, else polarity applied
  wire next_pin = (!run_i || !en_q) ? cfg_i.def : (next_raw ^ cfg_i.lvl);

  // ----------------------------------------------------------------
  // Waveform and pin registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw   <= 1'b0;
      en_q  <= 1'b0;
      pin_o <= 1'b0;
    end else begin
      raw   <= next_raw;
      en_q  <= cfg_i.en;
      pin_o <= next_pin;
    end
  end

  // Zero duty never raises the waveform, late disable still ends at default
  a_zero_inactive: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    run_i && load_i && duty_i == 16'h0000 |=> !raw)
    else $error("zero duty raised the waveform");
  a_dis_then_default: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
    run_i && en_q && !cfg_i.en ##1 run_i |=> pin_o == $past(cfg_i.def))
    else $error("disabled output missed its default");
endmodule : spt_chan
`default_nettype wire

// *** rtl/spt_timer.sv ***
/*
  Six-channel 16-bit PWM timer with AHB-Lite register slave,
  buffered compares, batch reload and synchronous slave start/stop.
  Assumes one clock, an AHB-Lite master with single word transfers,
  and a master timer run level when slave mode is used.
*/
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "spt_map.svh"

module spt_timer (
  input  wire logic        ref_clk_i,          // Peripheral clock
  input  wire logic        rst_b_i,            // Async reset, active low
  input  wire logic        hsel_i,             // AHB select
  input  wire logic [31:0] haddr_i,            // AHB address
  input  wire logic [1:0]  htrans_i,           // AHB transfer type
  input  wire logic        hwrite_i,           // AHB write
  input  wire logic [2:0]  hsize_i,            // AHB size, word only
  input  wire logic [31:0] hwdata_i,           // AHB write data
  input  wire logic        hready_i,           // AHB bus ready
  output logic             hreadyout_o,        // AHB slave ready
  output logic             hresp_o,            // AHB response
  output logic [31:0]      hrdata_o,           // AHB read data
  input  wire logic        master_run_i,       // Master timer running
  output logic [5:0]       pwm_output_o,       // PWM outputs
  output logic             period_interrupt_o  // Period event pulse
);
  localparam int NCH = `SPT_NCH;

  // ----------------------------------------------------------------
  // Bus data phase state
  // ----------------------------------------------------------------
  logic        dp_wr;      // Write data phase
  logic        dp_rd;      // Read data phase
  logic        rd_done;    // Read data loaded
  logic [19:0] dp_idx;     // Register index

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic        count_enable_bit;        // Run request
  logic        count_clock_select_bit;  // Count clock choice
  logic        sync_slave_mode_bit;     // Follow master
  logic [5:0]  output_enable_bit;       // Per output enable
  logic [5:0]  active_level_bit;        // Per output polarity
  logic [5:0]  default_level_bit;       // Per output idle level
  logic [15:0] period_compare;          // Period written
  logic [15:0] duty_compare [NCH];      // Duties written

  // ----------------------------------------------------------------
  // Timer core state
  // ----------------------------------------------------------------
  spt_pkg::spt_state_type state;        // Run state
  logic [15:0] up_counter;              // Count value
  logic [15:0] period_buf;              // Period in effect
  logic [15:0] duty_buf [NCH];          // Duties in effect
  logic        batch_pending_flag;      // Reload awaited
  logic        stop_q;                  // Stop one cycle after disable
  logic        tick;                    // Count clock pulse

  // Write decode against the captured index
  function automatic logic wr_hit(input logic [19:0] idx);
    wr_hit = dp_wr && (dp_idx == idx);
  endfunction : wr_hit

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire addr_ok   = hsel_i && hready_i && htrans_i[1];
  wire rd_wait   = dp_rd && !rd_done;
  wire [19:0] duty_off = dp_idx - `SPT_IDX_DUTY0;
  wire is_duty   = (dp_idx >= `SPT_IDX_DUTY0) && (duty_off < 20'h00006);
  wire [2:0] duty_sel = duty_off[2:0];
  wire [7:0] ctrl_rd = {count_enable_bit, 2'b00, count_clock_select_bit,
                        3'b000, sync_slave_mode_bit};
  wire [31:0] rd_mux =
    (dp_idx == `SPT_IDX_FLAG)   ? {31'h0, batch_pending_flag} :
    (dp_idx == `SPT_IDX_MON)    ? {26'h0, pwm_output_o} :
    (dp_idx == `SPT_IDX_CTRL)   ? {24'h0, ctrl_rd} :
    (dp_idx == `SPT_IDX_OUTC0)  ? {18'h0, active_level_bit, 2'b00,
                                   default_level_bit} :
    (dp_idx == `SPT_IDX_OUTC1)  ? {26'h0, output_enable_bit} :
    (dp_idx == `SPT_IDX_PERIOD) ? {16'h0, period_compare} :
    is_duty                     ? {16'h0, duty_compare[duty_sel]} :
    32'h0;

  assign hreadyout_o = !rd_wait;
  assign hresp_o     = 1'b0;

  // ----------------------------------------------------------------
  // Bus phase tracking and read data
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dp_wr    <= 1'b0;
      dp_rd    <= 1'b0;
      dp_idx   <= 20'h0;
      rd_done  <= 1'b0;
      hrdata_o <= 32'h0;
    end else begin
      rd_done <= rd_wait;
      // Read data after one wait state, so earlier writes are seen
      if (rd_wait) begin
        hrdata_o <= rd_mux;
      end
      if (hreadyout_o) begin
        dp_wr  <= addr_ok && hwrite_i;
        dp_rd  <= addr_ok && !hwrite_i;
        dp_idx <= haddr_i[21:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_enable_bit       <= 1'b0;
      count_clock_select_bit <= 1'b0;
      sync_slave_mode_bit    <= 1'b0;
      output_enable_bit      <= 6'h00;
      active_level_bit       <= 6'h00;
      default_level_bit      <= 6'h00;
      period_compare         <= `SPT_CMP_RST;
    end else begin
      if (wr_hit(`SPT_IDX_CTRL)) begin
        count_enable_bit       <= hwdata_i[`SPT_CTRL_CE];
        count_clock_select_bit <= hwdata_i[`SPT_CTRL_CKS];
        sync_slave_mode_bit    <= hwdata_i[`SPT_CTRL_MD];
      end
      if (wr_hit(`SPT_IDX_OUTC0)) begin
        active_level_bit  <= hwdata_i[`SPT_OUTC0_LVL +: 6];
        default_level_bit <= hwdata_i[5:0];
      end
      if (wr_hit(`SPT_IDX_OUTC1)) begin
        output_enable_bit <= hwdata_i[5:0];
      end
      if (wr_hit(`SPT_IDX_PERIOD)) begin
        period_compare <= hwdata_i[15:0];
      end
    end
  end

  // Duty compare registers, one per output
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < NCH; i++) begin
        duty_compare[i] <= `SPT_CMP_RST;
      end
    end else if (dp_wr && is_duty) begin
      duty_compare[duty_sel] <= hwdata_i[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Count clock
  // ----------------------------------------------------------------
  spt_tick u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .sel_i     (count_clock_select_bit),
    .tick_o    (tick)
  );

  // ----------------------------------------------------------------
  // Core decode
  // ----------------------------------------------------------------
  wire running   = (state == spt_pkg::SPT_RUNNING);
  wire run_en    = sync_slave_mode_bit ? master_run_i : count_enable_bit;
  wire start     = !running && run_en && tick;
  wire live_tick = running && !stop_q && tick;
  wire match     = live_tick && (up_counter == period_buf);
  wire step      = live_tick && !match;
  wire load_buf  = start || (match && batch_pending_flag);
  wire trig_set  = dp_wr && (dp_idx == `SPT_IDX_TRIG) && hwdata_i[`SPT_TRIG_REQ];
  wire next_pend = trig_set || (batch_pending_flag && !load_buf);
  wire next_run  = stop_q ? 1'b0 : (start ? 1'b1 : running);
  wire [15:0] cnt_inc  = up_counter + 16'h0001;
  wire [15:0] next_cnt = stop_q ? `SPT_CNT_IDLE :
                         (start || match) ? 16'h0000 :
                         step ? cnt_inc : up_counter;

  // ----------------------------------------------------------------
  // Counter, run state and period event
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state              <= spt_pkg::SPT_STOPPED;
      up_counter         <= `SPT_CNT_IDLE;
      stop_q             <= 1'b0;
      batch_pending_flag <= 1'b0;
      period_interrupt_o <= 1'b0;
    end else begin
      case (state)
        spt_pkg::SPT_STOPPED: state <= next_run ? spt_pkg::SPT_RUNNING : state;
        spt_pkg::SPT_RUNNING: state <= next_run ? state : spt_pkg::SPT_STOPPED;
        default:              state <= spt_pkg::SPT_STOPPED;
      endcase
      up_counter         <= next_cnt;
      stop_q             <= running && !run_en && !stop_q;
      batch_pending_flag <= next_pend;
      period_interrupt_o <= start || match;
    end
  end

  // Compare buffers, loaded only as a batch
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      period_buf <= `SPT_CMP_RST;
      for (int i = 0; i < NCH; i++) begin
        duty_buf[i] <= `SPT_CMP_RST;
      end
    end else if (load_buf) begin
      period_buf <= period_compare;
      for (int i = 0; i < NCH; i++) begin
        duty_buf[i] <= duty_compare[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output stages
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    wire spt_pkg::spt_out_cfg_type cfg = '{en:  output_enable_bit[g],
                                           lvl: active_level_bit[g],
                                           def: default_level_bit[g]};
    wire [15:0] duty_eff = load_buf ? duty_compare[g] : duty_buf[g];
    spt_chan u_chan (
      .ref_clk_i  (ref_clk_i),
      .rst_b_i    (rst_b_i),
      .run_i      (next_run),
      .load_i     (start || match),
      .step_i     (step),
      .cnt_next_i (cnt_inc),
      .duty_i     (duty_eff),
      .cfg_i      (cfg),
      .pin_o      (pwm_output_o[g])
    );
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_mon_read_back: assert property (rd_done && dp_idx == `SPT_IDX_MON
    |-> hrdata_o == {26'h0, $past(pwm_output_o)})
    else $error("monitor read differs from outputs");
  a_flag_read_back: assert property (rd_done && dp_idx == `SPT_IDX_FLAG
    |-> hrdata_o[0] == $past(batch_pending_flag))
    else $error("status read differs from pending flag");
  a_trig_set_pend: assert property (trig_set |=> batch_pending_flag)
    else $error("batch request did not set pending");
  a_trig_reads_zero: assert property (rd_done && dp_idx == `SPT_IDX_TRIG
    |-> hrdata_o == 32'h0)
    else $error("trigger register read nonzero");
  a_start_loads: assert property (start |=> running && up_counter == 16'h0000
    && period_buf == $past(period_compare) && batch_pending_flag == $past(trig_set))
    else $error("start did not load buffers");
  a_clear_reload: assert property (match && batch_pending_flag && !trig_set
    |=> !batch_pending_flag && duty_buf[0] == $past(duty_compare[0]))
    else $error("pending reload missed at clear");
  a_no_reload: assert property (match && !batch_pending_flag
    |=> period_buf == $past(period_buf))
    else $error("buffer changed without request");
  a_wrap_zero: assert property (match |=> up_counter == 16'h0000)
    else $error("counter did not clear at period match");
  a_idle_count: assert property (!running |-> up_counter == `SPT_CNT_IDLE)
    else $error("stopped counter not at idle value");
  a_stop_delay: assert property (running && !run_en && !stop_q
    |=> ##1 !running && pwm_output_o == $past(default_level_bit))
    else $error("stop did not follow disable");
  a_irq_start: assert property (start |=> period_interrupt_o)
    else $error("no period event at start");
  a_dis_default: assert property (!output_enable_bit[0]
    && !$past(output_enable_bit[0]) |=> pwm_output_o[0] == $past(default_level_bit[0]))
    else $error("disabled output not at default");

  // ----------------------------------------------------------------
  // Run control and batch assertions
  // ----------------------------------------------------------------
  a_pend_holds: assert property (batch_pending_flag && !load_buf
    |=> batch_pending_flag)
    else $error("pending flag dropped without reload");
  a_stop_idle: assert property (stop_q
    |=> !running && up_counter == `SPT_CNT_IDLE)
    else $error("stop did not idle the counter");
  a_stop_no_event: assert property (stop_q
    |=> !period_interrupt_o)
    else $error("period event after stop");
  a_late_tick_match: assert property (running && !run_en && !stop_q && tick
    && up_counter == period_buf |=> period_interrupt_o && up_counter == 16'h0000)
    else $error("coincident tick match lost");
  a_slave_start: assert property (sync_slave_mode_bit && master_run_i && tick
    && !running |=> running)
    else $error("slave did not start with master");
  a_trig_zero_noop: assert property (dp_wr && dp_idx == `SPT_IDX_TRIG
    && !hwdata_i[`SPT_TRIG_REQ] && !batch_pending_flag |=> !batch_pending_flag)
    else $error("zero trigger write set pending");
  a_clear_reload_all: assert property (match && batch_pending_flag
    |=> period_buf == $past(period_compare) && duty_buf[5] == $past(duty_compare[5]))
    else $error("batch reload incomplete");
  a_irq_pulse: assert property (period_interrupt_o
    |=> !period_interrupt_o)
    else $error("period event longer than one cycle");
  a_stop_pins_default: assert property (!running
    |-> pwm_output_o == $past(default_level_bit))
    else $error("stopped outputs not at default");
  a_step_count: assert property (step
    |=> up_counter == $past(up_counter) + 16'h0001)
    else $error("counter step wrong");
endmodule : spt_timer
`default_nettype wire

// *** test/spt_load_model.sv ***
/*
  Far-side model: the loads on the six PWM pins and on the period event line.
  Assumes the peripheral clock of the timer. Counts high cycles per line.
*/
`timescale 1ns/1ps
`default_nettype none

module spt_load_model (
  input  wire logic        ref_clk_i,  // Peripheral clock
  input  wire logic        clr_i,      // Clear all counters
  input  wire logic [6:0]  line_i,     // Pins, then event line on top
  output logic      [15:0] high_o [7]  // High cycles per line
);
  // ----------------------------------------------------------------
  // High-time counters
  // ----------------------------------------------------------------
  // Loads only sense levels and never drive back
  always_ff @(posedge ref_clk_i) begin
    for (int k = 0; k < 7; k++) begin
      high_o[k] <= clr_i ? 16'h0000 : high_o[k] + {15'h0000, line_i[k]};
    end
  end
endmodule : spt_load_model
`default_nettype wire

// *** test/spt_timer_tb_top.sv ***
/*
  Self-checking bench for the six-channel PWM timer.
  Assumes spt_timer with its AHB-Lite slave and the load model.
*/
`timescale 1ns/1ps
`default_nettype none
`include "spt_map.svh"

module spt_timer_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [15:0] PER = 16'h0005;  // Period compare
  logic        ref_clk = 1'b0;             // Peripheral clock
  logic        rst_b   = 1'b0;             // Reset, active low
  logic        hsel    = 1'b0;             // Bus select
  logic [31:0] haddr   = 32'h0000_0000;    // Bus address
  logic [1:0]  htrans  = 2'h0;             // Bus transfer type
  logic        hwrite  = 1'b0;             // Bus direction
  logic [31:0] hwdata  = 32'h0000_0000;    // Bus write data
  logic        mrun    = 1'b0;             // Master timer run level
  logic        clr     = 1'b0;             // Load counter clear
  logic        hrdy;                       // Slave ready
  logic        hresp;                      // Slave response
  logic [31:0] hrdata;                     // Read data
  logic [5:0]  pwm;                        // PWM pins
  logic        irq;                        // Period event
  logic [15:0] high [7];                   // Load counters
  logic        rd_dp   = 1'b0;             // Read data phase
  logic [31:0] rq [$];                     // Expected read data
  logic [15:0] duty [6];                   // Duty in effect
  logic [5:0]  lvl = 6'h02;                // Active low channels
  logic [5:0]  def = 6'h04;                // Default high channels
  logic [5:0]  en  = 6'h3F;                // Enabled channels
  int          n_errors   = 0;             // Mismatch count
  int          num_checks = 0;             // Comparison count
  int          seed       = 32'h5317;      // Random seed

  // Clock at 10 MHz
  always #50 ref_clk = ~ref_clk;

  spt_timer dut (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
    .master_run_i(mrun), .pwm_output_o(pwm), .period_interrupt_o(irq)
  );

  spt_load_model load (.ref_clk_i(ref_clk), .clr_i(clr), .line_i({irq, pwm}), .high_o(high));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic chk_cnt(input int k, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t line %0d high %0d expected %0d", $time, k, got, exp);
    end
  endtask : chk_cnt

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  // Bounded wait for ready sampled high at an edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hrdy !== 1'b1 && n < 20);
    if (hrdy !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t bus hang", $time);
      summarize();
    end
  endtask : wait_rdy

  // One single word transfer: address phase, then data phase
  task automatic bus(input logic wr, input logic [19:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel   <= 1'b1;
    haddr  <= {10'h000, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
  endtask : bus

  task automatic wr(input logic [19:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask : wr

  // Note the expected word, then read
  task automatic rd(input logic [19:0] idx, input logic [31:0] exp);
    rq.push_back(exp);
    bus(1'b0, idx, 32'h0000_0000);
  endtask : rd

  // Read monitor: oldest note against data at the ending edge
  always @(posedge ref_clk) begin
    if (rd_dp && hrdy === 1'b1) begin
      chk_rd(hrdata, rq.pop_front());
    end
    if (hrdy === 1'b1) begin
      rd_dp <= hsel && htrans[1] && !hwrite;
    end
  end

  // ----------------------------------------------------------------
  // Waveform measure over two periods
  // ----------------------------------------------------------------
  task automatic measure(input int div, input logic run, input string name);
    logic [15:0] w;
    logic [15:0] a;
    logic [15:0] e;
    w = (PER + 16'h0001) * 16'(2 * div);
    repeat (16) @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
    repeat (int'(w) + 1) @(posedge ref_clk);
    for (int k = 0; k < 6; k++) begin
      a = (duty[k] > PER) ? PER + 16'h0001 : duty[k];
      a = a * 16'(2 * div);
      e = (run && en[k]) ? (lvl[k] ? w - a : a) : (def[k] ? w : 16'h0000);
      chk_cnt(k, high[k], e);
    end
    chk_cnt(6, high[6], run ? 16'h0002 : 16'h0000);
    $display("test %s done at %0t", name, $time);
  endtask : measure

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    duty[0] = 16'h0000;
    duty[4] = 16'hFFFF;
    duty[5] = PER + 16'h0001;
    for (int k = 1; k < 4; k++) begin
      duty[k] = 16'h0001 + 16'($unsigned($random(seed)) % PER);
    end
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(`SPT_IDX_FLAG, 32'h0);
    rd(`SPT_IDX_MON, 32'h0);
    rd(20'hF06E0, 32'h0);
    wr(`SPT_IDX_TRIG, 32'h0);
    rd(`SPT_IDX_FLAG, 32'h0);
    wr(`SPT_IDX_TRIG, 32'h1);
    rd(`SPT_IDX_FLAG, 32'h1);
    wr(`SPT_IDX_TRIG, 32'h1);
    rd(`SPT_IDX_FLAG, 32'h1);
    rd(`SPT_IDX_TRIG, 32'h0);
    $display("test registers done at %0t", $time);
    wr(`SPT_IDX_OUTC0, {18'h0, lvl, 2'b00, def});
    wr(`SPT_IDX_OUTC1, {26'h0, en});
    wr(`SPT_IDX_PERIOD, {16'h0, PER});
    for (int k = 0; k < 6; k++) begin
      wr(`SPT_IDX_DUTY0 + 20'(k), {16'h0, duty[k]});
    end
    wr(`SPT_IDX_CTRL, 32'h80);
    measure(2, 1'b1, "start");
    rd(`SPT_IDX_FLAG, 32'h0);
    wr(`SPT_IDX_DUTY0 + 20'h1, {16'h0, PER - duty[1] + 16'h0001});
    measure(2, 1'b1, "no reload");
    wr(`SPT_IDX_TRIG, 32'h1);
    duty[1] = PER - duty[1] + 16'h0001;
    measure(2, 1'b1, "batch reload");
    rd(`SPT_IDX_FLAG, 32'h0);
    wr(`SPT_IDX_CTRL, 32'h00);
    measure(2, 1'b0, "stop");
    rd(`SPT_IDX_MON, {26'h0, def});
    wr(`SPT_IDX_CTRL, 32'h90);
    measure(8, 1'b1, "slow clock");
    wr(`SPT_IDX_OUTC1, 32'h0);
    en = 6'h00;
    measure(8, 1'b1, "outputs off");
    wr(`SPT_IDX_OUTC1, 32'h3F);
    en = 6'h3F;
    wr(`SPT_IDX_CTRL, 32'h01);
    measure(2, 1'b0, "slave idle");
    mrun <= 1'b1;
    measure(2, 1'b1, "slave run");
    mrun <= 1'b0;
    measure(2, 1'b0, "slave stop");
    summarize();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("[FAIL] %0t run limit reached", $time);
    summarize();
  end
endmodule : spt_timer_tb_top
`default_nettype wire
